// ==== design/dar_params.svh ====
`ifndef DAR_PARAMS_SVH
`define DAR_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DAR_OFS_CTRL 8'h00
`define DAR_OFS_CMD 8'h04
`define DAR_OFS_ADDR 8'h08
`define DAR_OFS_STAT 8'h0C
`define DAR_OFS_TIME 8'h10

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DAR_CTRL_EN_BIT 0
`define DAR_CTRL_RST 1'b0
`define DAR_CMD_OP_LSB 0
`define DAR_CMD_WR_BIT 3
`define DAR_CMD_CNT_LSB 8
`define DAR_ADDR_COL_LSB 0
`define DAR_ADDR_ROW_LSB 8
`define DAR_ADDR_BANK_LSB 16
`define DAR_ADDR_RST 18'h00000
`define DAR_STAT_BUSY_BIT 0
`define DAR_STAT_EOC_BIT 1
`define DAR_STAT_FLAG_BIT 2
`define DAR_STAT_CNT_LSB 8
`define DAR_TIME_HOLD_LSB 0
`define DAR_TIME_HOLD_RST 4'h1

// ----------------------------------------
// Command codes and device mode pin codes
// ----------------------------------------
`define DAR_OP_REFRESH 3'h0
`define DAR_OP_ACCESS 3'h1
`define DAR_OP_AUTO 3'h2
`define DAR_OP_INIT 3'h3
`define DAR_OP_CNT_RST 3'h4
`define DAR_MODE_REFRESH_SELECT 3'h0
`define DAR_MODE_INIT 3'h3
`define DAR_MODE_EXT 3'h4
`define DAR_MODE_AUTO 3'h5

// ----------------------------------------
// Timing: least times, rounded up to cycles
// ----------------------------------------
`define DAR_CLK_NS 40
`define DAR_CEIL(ns) (((ns) + `DAR_CLK_NS - 1) / `DAR_CLK_NS)
`define DAR_LEAD_NS 10
`define DAR_LEAD_CYC `DAR_CEIL(`DAR_LEAD_NS)
`define DAR_COLV_NS 58
`define DAR_COLV_CYC `DAR_CEIL(`DAR_COLV_NS)
`define DAR_CAS_NS 120
`define DAR_CAS_CYC `DAR_CEIL(`DAR_CAS_NS)
`define DAR_RAS_NS 120
`define DAR_RAS_CYC `DAR_CEIL(`DAR_RAS_NS)
`define DAR_AUTO_NS 280
`define DAR_AUTO_CYC `DAR_CEIL(`DAR_AUTO_NS)
`define DAR_PRE_NS 120
`define DAR_PRE_CYC `DAR_CEIL(`DAR_PRE_NS)
`define DAR_PULL_NS 80
`define DAR_PULL_CYC `DAR_CEIL(`DAR_PULL_NS)

`endif

// ==== design/dar_pkg.sv ====
package dar_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_SETUP, ST_LATCH, ST_LEAD, ST_RAS, ST_COL, ST_CAS, ST_END, ST_PRE, ST_PULL
    } dar_state_e;
endpackage

// ==== design/dar_sync.sv ====
`timescale 1ns/1ps
module dar_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic d,
    output logic q
);
    logic meta_reg;

    // Idle level of an open-collector line is high
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= 1'b1;
            q <= 1'b1;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ==== design/dar_ctrl.sv ====
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dar_params.svh"
// What this block does
// - Write input is high for reads, set low before column strobe for writes.
// - Pulling the flag pin low resets the device counter to zero.
// - Burst refresh toggles row strobe with refresh select held low.
// - All-bank write holds write low and increments the address each cycle.
// - Row/column select falls only after the row hold time.
// - Row strobe may fall any time after the address latch strobe falls.
module dar_ctrl
    import dar_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic [7:0] row_addr_out,
    output logic [7:0] col_addr_out,
    output logic bank_sel_hi,
    output logic bank_sel_lo,
    output logic address_latch_strobe,
    output logic row_strobe_in,
    output logic column_strobe_in,
    output logic row_col_sel,
    output logic chip_sel_n,
    output logic write_in,
    output logic refresh_select,
    output logic mode_bit_1,
    output logic mode_bit_0,
    input wire logic count_flag_i,
    output logic count_flag_o,
    output logic count_flag_oe
);
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic wr_pend_reg;
    logic [7:0] wadr_reg;
    logic ctrl_en_reg;
    logic [17:0] addr_reg;
    logic [3:0] hold_reg;
    logic cmd_go_reg;
    logic [2:0] cmd_op_reg;
    logic cmd_wr_reg;
    logic [7:0] cmd_cnt_reg;
    logic eoc_reg;
    logic [7:0] mirror_reg;
    logic flag_sync;
    dar_state_e state_reg;
    logic busy;
    logic take;

    assign busy = (state_reg != ST_IDLE) || cmd_go_reg;
    assign take = hsel && hready && htrans[1];

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        rd_mux = 32'h00000000;
        case (a)
            `DAR_OFS_CTRL: rd_mux[`DAR_CTRL_EN_BIT] = ctrl_en_reg;
            `DAR_OFS_ADDR: rd_mux[17:0] = addr_reg;
            `DAR_OFS_STAT: begin
                rd_mux[`DAR_STAT_BUSY_BIT] = busy;
                rd_mux[`DAR_STAT_EOC_BIT] = eoc_reg;
                rd_mux[`DAR_STAT_FLAG_BIT] = flag_sync;
                rd_mux[`DAR_STAT_CNT_LSB +: 8] = mirror_reg;
            end
            `DAR_OFS_TIME: rd_mux[`DAR_TIME_HOLD_LSB +: 4] = hold_reg;
            default: rd_mux = 32'h00000000;
        endcase
    endfunction

    // Zero wait states: read data is registered in the address phase
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wr_pend_reg <= 1'b0;
            wadr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= take && hwrite;
            if (take) begin
                wadr_reg <= haddr[7:0];
            end
            if (take && !hwrite) begin
                hrdata <= rd_mux(haddr[7:0]);
            end
        end
    end

    // A command written while busy is dropped; software polls busy first
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_en_reg <= `DAR_CTRL_RST;
            addr_reg <= `DAR_ADDR_RST;
            hold_reg <= `DAR_TIME_HOLD_RST;
            cmd_go_reg <= 1'b0;
            cmd_op_reg <= `DAR_OP_REFRESH;
            cmd_wr_reg <= 1'b0;
            cmd_cnt_reg <= 8'h00;
        end else begin
            cmd_go_reg <= 1'b0;
            if (wr_pend_reg) begin
                case (wadr_reg)
                    `DAR_OFS_CTRL: ctrl_en_reg <= hwdata[`DAR_CTRL_EN_BIT];
                    `DAR_OFS_ADDR: addr_reg <= hwdata[17:0];
                    `DAR_OFS_TIME: begin
                        hold_reg <= (hwdata[3:0] == 4'h0) ? 4'h1 : hwdata[3:0];
                    end
                    `DAR_OFS_CMD: begin
                        if (!busy) begin
                            cmd_go_reg <= 1'b1;
                            cmd_op_reg <= hwdata[`DAR_CMD_OP_LSB +: 3];
                            cmd_wr_reg <= hwdata[`DAR_CMD_WR_BIT];
                            cmd_cnt_reg <= hwdata[`DAR_CMD_CNT_LSB +: 8];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            chip_sel_n <= 1'b1;
        end else begin
            chip_sel_n <= !ctrl_en_reg;
        end
    end

    // ----------------------------------------
    // Count flag sensing and counter mirror
    // ----------------------------------------
    logic ras_prev_reg;
    logic [1:0] win_dly_reg;
    logic eoc_clr;

    dar_sync u_flag_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(count_flag_i),
        .q(flag_sync)
    );

    assign eoc_clr = wr_pend_reg && (wadr_reg == `DAR_OFS_STAT) && hwdata[`DAR_STAT_EOC_BIT];

    // Window is delayed to line up with the synchroniser's two cycles
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            win_dly_reg <= 2'b00;
            eoc_reg <= 1'b0;
        end else begin
            win_dly_reg <= {win_dly_reg[0], !row_strobe_in && !refresh_select && !count_flag_oe};
            if (win_dly_reg[1] && !flag_sync) begin
                eoc_reg <= 1'b1;
            end else if (eoc_clr) begin
                eoc_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ras_prev_reg <= 1'b1;
            mirror_reg <= 8'h00;
        end else begin
            ras_prev_reg <= row_strobe_in;
            if (count_flag_oe) begin
                mirror_reg <= 8'h00;
            // All-bank write also strobes rows with M2 low, but the device does not count them
            end else if (row_strobe_in && !ras_prev_reg && !refresh_select
                && !(mode_bit_1 && mode_bit_0)) begin
                mirror_reg <= mirror_reg + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Pin sequencer
    // ----------------------------------------
    logic [3:0] tmr_reg;
    logic [2:0] op_reg;
    logic [7:0] left_reg;
    logic [17:0] cur_reg;
    logic tdone;

    assign tdone = (tmr_reg <= 4'h1);
    assign row_addr_out = cur_reg[`DAR_ADDR_ROW_LSB +: 8];
    assign col_addr_out = cur_reg[`DAR_ADDR_COL_LSB +: 8];
    assign bank_sel_hi = cur_reg[`DAR_ADDR_BANK_LSB + 1];
    assign bank_sel_lo = cur_reg[`DAR_ADDR_BANK_LSB];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            tmr_reg <= 4'h0;
            op_reg <= `DAR_OP_REFRESH;
            left_reg <= 8'h00;
            cur_reg <= `DAR_ADDR_RST;
            address_latch_strobe <= 1'b0;
            row_strobe_in <= 1'b1;
            column_strobe_in <= 1'b1;
            row_col_sel <= 1'b1;
            write_in <= 1'b1;
            {refresh_select, mode_bit_1, mode_bit_0} <= `DAR_MODE_EXT;
            count_flag_o <= 1'b0;
            count_flag_oe <= 1'b0;
        end else begin
            if (!tdone) begin
                tmr_reg <= tmr_reg - 4'h1;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_go_reg) begin
                        op_reg <= cmd_op_reg;
                        left_reg <= cmd_cnt_reg;
                        cur_reg <= addr_reg;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    case (op_reg)
                        `DAR_OP_REFRESH: begin
                            {refresh_select, mode_bit_1, mode_bit_0} <= `DAR_MODE_REFRESH_SELECT;
                            tmr_reg <= 4'(`DAR_LEAD_CYC);
                            state_reg <= ST_LEAD;
                        end
                        `DAR_OP_CNT_RST: begin
                            count_flag_oe <= 1'b1;
                            tmr_reg <= 4'(`DAR_PULL_CYC);
                            state_reg <= ST_PULL;
                        end
                        `DAR_OP_AUTO: begin
                            {refresh_select, mode_bit_1, mode_bit_0} <= `DAR_MODE_AUTO;
                            write_in <= !cmd_wr_reg;
                            address_latch_strobe <= 1'b1;
                            state_reg <= ST_LATCH;
                        end
                        `DAR_OP_INIT: begin
                            {refresh_select, mode_bit_1, mode_bit_0} <= `DAR_MODE_INIT;
                            write_in <= 1'b0;
                            address_latch_strobe <= 1'b1;
                            state_reg <= ST_LATCH;
                        end
                        default: begin
                            {refresh_select, mode_bit_1, mode_bit_0} <= `DAR_MODE_EXT;
                            write_in <= !cmd_wr_reg;
                            address_latch_strobe <= 1'b1;
                            state_reg <= ST_LATCH;
                        end
                    endcase
                end
                ST_LATCH: begin
                    address_latch_strobe <= 1'b0;
                    state_reg <= ST_LEAD;
                    tmr_reg <= 4'h1;
                end
                ST_LEAD: begin
                    if (tdone) begin
                        row_strobe_in <= 1'b0;
                        state_reg <= ST_RAS;
                        if (op_reg == `DAR_OP_AUTO) begin
                            tmr_reg <= 4'(`DAR_AUTO_CYC);
                        end else if (op_reg == `DAR_OP_REFRESH) begin
                            tmr_reg <= 4'(`DAR_RAS_CYC);
                        end else begin
                            tmr_reg <= hold_reg;
                        end
                    end
                end
                ST_RAS: begin
                    if (tdone) begin
                        if (op_reg == `DAR_OP_REFRESH || op_reg == `DAR_OP_AUTO) begin
                            state_reg <= ST_END;
                        end else begin
                            row_col_sel <= 1'b0;
                            tmr_reg <= 4'(`DAR_COLV_CYC);
                            state_reg <= ST_COL;
                        end
                    end
                end
                ST_COL: begin
                    if (tdone) begin
                        column_strobe_in <= 1'b0;
                        tmr_reg <= 4'(`DAR_CAS_CYC);
                        state_reg <= ST_CAS;
                    end
                end
                ST_CAS: begin
                    if (tdone) begin
                        state_reg <= ST_END;
                    end
                end
                ST_END: begin
                    row_strobe_in <= 1'b1;
                    column_strobe_in <= 1'b1;
                    row_col_sel <= 1'b1;
                    tmr_reg <= 4'(`DAR_PRE_CYC);
                    state_reg <= ST_PRE;
                end
                ST_PRE: begin
                    if (tdone) begin
                        if (left_reg != 8'h00 && op_reg == `DAR_OP_REFRESH) begin
                            left_reg <= left_reg - 8'h01;
                            row_strobe_in <= 1'b0;
                            tmr_reg <= 4'(`DAR_RAS_CYC);
                            state_reg <= ST_RAS;
                        end else if (left_reg != 8'h00 && op_reg == `DAR_OP_INIT) begin
                            left_reg <= left_reg - 8'h01;
                            cur_reg[15:0] <= cur_reg[15:0] + 16'h0001;
                            state_reg <= ST_SETUP;
                        end else begin
                            {refresh_select, mode_bit_1, mode_bit_0} <= `DAR_MODE_EXT;
                            write_in <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_PULL: begin
                    if (tdone) begin
                        count_flag_oe <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_REFRESH_SELECT_LEAD: assert property ($fell(row_strobe_in) && !refresh_select
        |-> $past(!refresh_select)) else $error("refresh select did not lead row strobe");
    AST_WIN_SETTLED: assert property ($fell(column_strobe_in)
        |-> write_in == $past(write_in) && write_in == $past(write_in, 2))
        else $error("write moved near CAS");
    AST_RC_AFTER_RAS: assert property ($fell(row_col_sel)
        |-> $past(!row_strobe_in)) else $error("select fell before row strobe");
    AST_CAS_AFTER_COL: assert property ($fell(column_strobe_in)
        |-> !row_col_sel && $past(!row_col_sel, 2)) else $error("column strobe too early");
    AST_INIT_WRITE: assert property (!row_strobe_in && !refresh_select && mode_bit_1
        |-> !write_in) else $error("all-bank write without write low");
    AST_MIRROR_INC: assert property ($rose(row_strobe_in) && !refresh_select
        && !count_flag_oe && !(mode_bit_1 && mode_bit_0)
        |=> mirror_reg == $past(mirror_reg) + 8'h01) else $error("mirror missed step");
    AST_PULL_CLEARS: assert property ($rose(count_flag_oe)
        |=> mirror_reg == 8'h00 && count_flag_oe) else $error("counter reset not held");
    AST_ADS_BEFORE_RAS: assert property ($fell(row_strobe_in)
        |-> !address_latch_strobe) else $error("row strobe with latch open");
    AST_BURST_HOLD: assert property ($rose(row_strobe_in) && !refresh_select
        && left_reg != 8'h00 |=> !refresh_select [*2])
        else $error("refresh select rose in burst");
    AST_AUTO_NO_CAS: assert property (refresh_select && !mode_bit_1 && mode_bit_0
        |-> column_strobe_in && row_col_sel) else $error("auto mode used select pins");
    AST_EOC_SET_WINS: assert property (win_dly_reg[1] && !flag_sync
        |=> eoc_reg) else $error("count flag lost");

    COV_REFRESH: cover property ($rose(row_strobe_in) && !refresh_select);
    COV_EXT_CAS: cover property ($fell(column_strobe_in) && mode_bit_0 == 1'b0);
    COV_EOC: cover property ($rose(eoc_reg));
    COV_CNT_RST: cover property ($fell(count_flag_oe));
endmodule

// ==== test/dar_dev_model.sv ====
`timescale 1ns/1ps
module dar_dev_model #(
    parameter logic [7:0] END_COUNT = 8'h7F
) (
    input wire logic [7:0] row_addr_out,
    input wire logic [7:0] col_addr_out,
    input wire logic bank_sel_hi,
    input wire logic bank_sel_lo,
    input wire logic address_latch_strobe,
    input wire logic row_strobe_in,
    input wire logic column_strobe_in,
    input wire logic row_col_sel,
    input wire logic chip_sel_n,
    input wire logic write_in,
    input wire logic refresh_select,
    input wire logic mode_bit_1,
    input wire logic mode_bit_0,
    input wire logic count_flag_io,
    output logic flag_pull,
    output logic [7:0] mux_address_out,
    output logic [3:0] ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [7:0] dev_count
);
    // ----------------------------------------
    // Device behaviour, delays left out except the row hold and the column strobe lag
    // ----------------------------------------
    logic [7:0] row_l, col_l;
    logic [1:0] bank_l;
    logic refr, auto_m, off, auto_col, done;
    wire row_dly, col_cas;
    assign refr = !refresh_select && !(mode_bit_1 && mode_bit_0);
    assign auto_m = {refresh_select, mode_bit_1, mode_bit_0} == 3'b101;
    assign off = chip_sel_n && !refr;
    assign #30 row_dly = row_strobe_in;
    // A row strobe pulse shorter than the row hold never reaches the columns
    assign auto_col = auto_m && !row_strobe_in && !row_dly;
    // Column strobe trails the column address so a capture on its fall sees columns
    assign #8 col_cas = auto_col;
    always_latch begin
        if (address_latch_strobe) begin
            row_l <= row_addr_out;
            col_l <= col_addr_out;
            bank_l <= {bank_sel_hi, bank_sel_lo};
        end
    end
    assign mux_address_out = off ? 8'hZZ : refr ? dev_count
        : (row_col_sel && !auto_col) ? row_l : col_l;
    assign ras_n = off ? 4'hF : !refresh_select ? {4{row_strobe_in}}
        : ~({3'h0, !row_strobe_in} << bank_l);
    assign cas_n = off || refr ? 1'b1 : auto_m ? !col_cas
        : row_col_sel || column_strobe_in;
    assign we_n = off ? 1'b1 : write_in;
    assign flag_pull = refr && !row_strobe_in && dev_count == END_COUNT;
    initial begin
        dev_count = 8'h00;
        done = 1'b0;
    end
    always @(negedge row_strobe_in) done <= refr;
    // Once per refresh, whichever strobe rises first
    always @(posedge row_strobe_in or posedge refresh_select) begin
        if (done) begin
            dev_count <= dev_count + 8'h01;
            done <= 1'b0;
        end
    end
    // Our own flag pull must not clear the count
    always @(negedge count_flag_io) if (!flag_pull) dev_count <= 8'h00;
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`include "dar_params.svh"
module tb_top;
    logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] row_addr_out, col_addr_out, mux_address_out, dev_count, ras_q, cas_q;
    logic bank_sel_hi, bank_sel_lo, address_latch_strobe, row_strobe_in, column_strobe_in;
    logic row_col_sel, chip_sel_n, write_in, refresh_select, mode_bit_1, mode_bit_0;
    logic count_flag_o, count_flag_oe, flag_pull, cas_n, we_n, cas_we;
    logic [3:0] ras_n, cas_ras, ras_v;
    wire count_flag_io;
    wire ras_all = &ras_n;
    int num_errors = 0, checks = 0, cyc = 0, ras_cnt = 0, cas_cnt = 0, c0, r0;
    // ----------------------------------------
    // Wiring: pull-up line, low while either side pulls
    // ----------------------------------------
    assign count_flag_io = !((count_flag_oe && !count_flag_o) || flag_pull);
    assign hready = hreadyout;
    dar_ctrl dut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hrdata, .hresp, .row_addr_out, .col_addr_out, .bank_sel_hi, .bank_sel_lo,
        .address_latch_strobe, .row_strobe_in, .column_strobe_in, .row_col_sel, .chip_sel_n,
        .write_in, .refresh_select, .mode_bit_1, .mode_bit_0, .count_flag_i(count_flag_io),
        .count_flag_o, .count_flag_oe);
    dar_dev_model dev (.row_addr_out, .col_addr_out, .bank_sel_hi, .bank_sel_lo,
        .address_latch_strobe, .row_strobe_in, .column_strobe_in, .row_col_sel, .chip_sel_n,
        .write_in, .refresh_select, .mode_bit_1, .mode_bit_0, .count_flag_io, .flag_pull,
        .mux_address_out, .ras_n, .cas_n, .we_n, .dev_count);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge ras_all) begin
        ras_cnt++;
        ras_q = mux_address_out;
        ras_v = ras_n;
    end
    always @(negedge cas_n) begin
        cas_cnt++;
        cas_q = mux_address_out;
        cas_ras = ras_n;
        cas_we = we_n;
    end
    task automatic final_report();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Single word transfer; hready gates both phases, read data taken at data end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h00000000, {31'h0, hresp});
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        chk(what, exp, rd);
    endtask
    task automatic cmd(input logic [2:0] op, input logic wr, input logic [7:0] n);
        bus(1'b1, `DAR_OFS_CMD, {16'h0000, n, 4'h0, wr, op});
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            bus(1'b0, `DAR_OFS_STAT, 32'h00000000);
            n++;
        end while (rd[0] !== 1'b0 && n < 1000);
        chk("busy", 32'h00000000, {31'h0, rd[0]});
    endtask
    initial begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        repeat (10) @(posedge clk);
        chk("idle pins", 32'h1F8, {23'h0, row_strobe_in, column_strobe_in, row_col_sel,
            write_in, chip_sel_n, refresh_select, mode_bit_1, mode_bit_0,
            address_latch_strobe});
        chk("power count", 32'h00000000, dev_count);
        sys_rst <= 1'b0;
        rd_chk("ctrl", `DAR_OFS_CTRL, 32'h00000000);
        rd_chk("addr", `DAR_OFS_ADDR, 32'h00000000);
        rd_chk("time", `DAR_OFS_TIME, 32'h00000001);
        rd_chk("unmapped", 8'h14, 32'h00000000);
        rd_chk("status", `DAR_OFS_STAT, 32'h00000004);
        bus(1'b1, `DAR_OFS_TIME, 32'h00000000);
        rd_chk("time zero", `DAR_OFS_TIME, 32'h00000001);
        bus(1'b1, `DAR_OFS_CTRL, 32'h00000001);
        rd_chk("ctrl on", `DAR_OFS_CTRL, 32'h00000001);
        chk("selected", 32'h00000000, chip_sel_n);
        c0 = cas_cnt;
        for (int b = 0; b < 4; b++) begin
            bus(1'b1, `DAR_OFS_ADDR, {14'h0, b[1:0], 8'h5A + 8'(b), 8'hC3 ^ 8'(b)});
            cmd(b[0] ? `DAR_OP_AUTO : `DAR_OP_ACCESS, b[1], 8'h00);
            wait_idle();
            chk("row", {24'h0, 8'h5A + 8'(b)}, ras_q);
            chk("col", {24'h0, 8'hC3 ^ 8'(b)}, cas_q);
            chk("bank", {28'h0, ~(4'h1 << b[1:0])}, cas_ras);
            chk("write", {31'h0, !b[1]}, cas_we);
            chk("cas count", c0 + b + 1, cas_cnt);
        end
        bus(1'b1, `DAR_OFS_ADDR, 32'h000012FF);
        c0 = cas_cnt;
        cmd(`DAR_OP_INIT, 1'b0, 8'h01);
        wait_idle();
        chk("init cycles", c0 + 2, cas_cnt);
        chk("init addr", 32'h00001300, {ras_q, cas_q});
        chk("init banks", 32'h00000000, cas_ras);
        chk("init write", 32'h00000000, cas_we);
        r0 = ras_cnt;
        c0 = cas_cnt;
        cmd(`DAR_OP_REFRESH, 1'b0, 8'h7F);
        wait_idle();
        chk("refreshes", r0 + 128, ras_cnt);
        chk("refresh cas", c0, cas_cnt);
        chk("refresh row", 32'h0000007F, ras_q);
        chk("refresh banks", 32'h00000000, ras_v);
        chk("dev count", 32'h00000080, dev_count);
        rd_chk("end of count", `DAR_OFS_STAT, 32'h00008006);
        bus(1'b1, `DAR_OFS_STAT, 32'h00000002);
        rd_chk("eoc clear", `DAR_OFS_STAT, 32'h00008004);
        cmd(`DAR_OP_REFRESH, 1'b0, 8'h7F);
        wait_idle();
        chk("wrap count", 32'h00000000, dev_count);
        rd_chk("wrap status", `DAR_OFS_STAT, 32'h00000004);
        cmd(`DAR_OP_REFRESH, 1'b0, 8'h00);
        cmd(`DAR_OP_REFRESH, 1'b0, 8'h00);
        wait_idle();
        chk("busy drop", 32'h00000001, dev_count);
        cmd(`DAR_OP_CNT_RST, 1'b0, 8'h00);
        wait_idle();
        chk("count reset", 32'h00000000, dev_count);
        rd_chk("reset status", `DAR_OFS_STAT, 32'h00000004);
        bus(1'b1, `DAR_OFS_CTRL, 32'h00000000);
        rd_chk("ctrl off", `DAR_OFS_CTRL, 32'h00000000);
        chk("deselected", 32'h00000001, chip_sel_n);
        final_report();
    end
endmodule
